/* tb/counter_asserts.sv */
// Port checker for the event counter top.
// Assumes one clock and a synchronous active-high reset.
module counter_asserts (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [11:0] paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        count_pulse_in,
    input wire logic        count_err_in,
    input wire logic        reload_in,
    input wire logic        reload_err_in,
    input wire logic        target_hit
);
    timeunit 1ns;
    timeprecision 1ns;
    import counter_pkg::*;
    // ------------------------------
    // Helpers
    // ------------------------------
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    logic nwr; // No register write
    logic rds; // Status read setup
    assign nwr = !(psel && penable && pwrite);
    assign rds = psel && !penable && !pwrite && paddr == STATUS_OFF;
    // ------------------------------
    // Properties
    // ------------------------------
    AST_RST_LOAD: assert property ($fell(rst) |-> target_hit)
        else $error("no hit after reset");
    AST_BOTH_ERR: assert property (count_err_in && reload_err_in && nwr
        |=> target_hit == $past(target_hit)) else $error("moved in errors");
    AST_CNT_ERR: assert property (count_err_in && $stable(reload_in)
        && nwr |=> $stable(target_hit)) else $error("counted in error");
    AST_RLD_ERR: assert property (reload_err_in && nwr
        && $stable(count_pulse_in) |=> $stable(target_hit))
        else $error("reloaded in error");
    AST_QUIET: assert property ($stable(count_pulse_in) && nwr
        && $stable(reload_in) |=> $stable(target_hit))
        else $error("output moved alone");
    AST_STAT_HIT: assert property (rds
        |=> prdata[STAT_HIT_BIT] == $past(target_hit)) else $error("hit bit");
    AST_STAT_ERR: assert property (rds
        |=> prdata[STAT_CERR_BIT] == $past(count_err_in, 2))
        else $error("error bit");
    AST_UNMAP: assert property (psel && penable && paddr > STATUS_OFF
        |-> pslverr && pready) else $error("no slave error");
endmodule
bind down_event_counter counter_asserts chk (.clk, .rst, .paddr, .psel,
    .penable, .pwrite, .prdata, .pready, .pslverr, .count_pulse_in,
    .count_err_in, .reload_in, .reload_err_in, .target_hit);

/* tb/down_event_counter_tb.sv */
// Self-checking bench for the event counter.
// Assumes the checker binds itself and the source model drives inputs.
module down_event_counter_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import counter_pkg::*;
    logic        clk = 1'h0, rst = 1'h1, psel = 1'h0;
    logic        penable = 1'h0, pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, serr, target_hit;
    logic        count_pulse_in, count_err_in, reload_in, reload_err_in;
    int          mismatches = 0, n_checks = 0;
    // 25 MHz clock
    always #20 clk = ~clk;
    down_event_counter dut (.clk, .rst, .paddr, .psel, .penable, .pwrite,
        .pwdata, .prdata, .pready, .pslverr, .count_pulse_in, .count_err_in,
        .reload_in, .reload_err_in, .target_hit);
    signal_source src (.clk, .count_pulse_in, .count_err_in, .reload_in,
        .reload_err_in);
    // ------------------------------
    // Bus and compare tasks
    // ------------------------------
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        do @(posedge clk); while (pready !== 1'h1);
        rd = prdata;
        serr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic chk32(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic chk1(input logic g, input logic e);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %0t bit got %b want %b", $time, g, e);
        end
    endtask
    // Count and hit through status and the pin
    task automatic status(input count_type c, input logic h);
        apb(1'h0, STATUS_OFF, 32'h0);
        chk32(rd & 32'h0001FFFF, {15'h0000, h, 2'h0, c});
        chk1(target_hit, h);
    endtask
    task automatic rpulse();
        src.rset(1'h1);
        src.rset(1'h0);
    endtask
    // ------------------------------
    // Scenarios
    // ------------------------------
    task automatic t_reset();
        apb(1'h0, CTRL_OFF, 32'h0);
        chk32(rd, 32'h00000011);
        status(COUNT_ZERO, 1'h1);
    endtask
    task automatic t_down();
        apb(1'h1, LOAD_OFF, 32'h2);
        apb(1'h1, TARGET_OFF, COUNT_MAX_W);
        rpulse();
        status(14'h0002, 1'h0);
        src.step();
        src.step();
        status(COUNT_ZERO, 1'h0);
        src.step();
        status(COUNT_MAX, 1'h1);
        src.step();
        status(14'h270E, 1'h0);
    endtask
    task automatic t_edges();
        count_type c;
        edge_type  m;
        // Rising, falling, then the code that counts nothing
        for (int i = 1; i < 4; i++) begin
            m = edge_type'(i);
            apb(1'h1, CTRL_OFF, 32'h11 | (32'(m) << 2));
            rpulse();
            c = 14'h0002;
            repeat (2) begin
                if ((m == EDGE_RISE && src.count_pulse_in === 1'h0) ||
                    (m == EDGE_FALL && src.count_pulse_in === 1'h1)) begin
                    c = c - COUNT_ONE;
                end
                src.step();
                status(c, 1'h0);
            end
        end
        apb(1'h1, CTRL_OFF, 32'h01);
        apb(1'h1, LOAD_OFF, 32'h5);
        src.rset(1'h1);
        status(c, 1'h0);
        src.rset(1'h0);
        status(14'h0005, 1'h0);
    endtask
    task automatic t_latch();
        apb(1'h1, CTRL_OFF, 32'h13);
        apb(1'h1, LOAD_OFF, 32'h3);
        apb(1'h1, TARGET_OFF, 32'h2);
        rpulse();
        status(14'h0003, 1'h0);
        src.step();
        status(14'h0002, 1'h1);
        src.step();
        status(14'h0001, 1'h1);
        rpulse();
        status(14'h0003, 1'h0);
    endtask
    task automatic t_errors();
        apb(1'h1, CTRL_OFF, 32'h11);
        src.set_err(1'h1, 1'h0);
        src.step();
        status(14'h0003, 1'h0);
        apb(1'h1, LOAD_OFF, 32'h4);
        rpulse();
        status(14'h0004, 1'h0);
        src.set_err(1'h0, 1'h1);
        src.step();
        src.step();
        rpulse();
        status(14'h0002, 1'h1);
        src.set_err(1'h1, 1'h1);
        src.step();
        rpulse();
        status(14'h0002, 1'h1);
        src.set_err(1'h0, 1'h0);
    endtask
    task automatic t_up();
        apb(1'h1, CTRL_OFF, 32'h10);
        apb(1'h1, LOAD_OFF, COUNT_MAX_W);
        rpulse();
        src.step();
        status(COUNT_ZERO, 1'h0);
        src.step();
        src.step();
        status(14'h0002, 1'h1);
        apb(1'h0, 12'h010, 32'h0);
        chk32(rd, 32'h0);
        chk1(serr, 1'h1);
    endtask
    // Mid-run reset with the count input high: no false edge after it
    task automatic t_rerun();
        rst <= 1'h1;
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        status(COUNT_ZERO, 1'h1);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'h0;
        t_reset();
        t_down();
        t_edges();
        t_latch();
        t_errors();
        t_up();
        t_rerun();
        finish_test();
    end
    // Watchdog
    initial begin
        #(40 * 4000);
        mismatches++;
        finish_test();
    end
endmodule

/* tb/signal_source.sv */
// Upstream source model: count and reload inputs with error flags.
// Assumes the bench calls its tasks; changes land after a rising edge.
module signal_source (
    input  wire logic clk,
    output logic      count_pulse_in,
    output logic      count_err_in,
    output logic      reload_in,
    output logic      reload_err_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle levels at time zero
    initial begin
        count_pulse_in = 1'h0;
        count_err_in = 1'h0;
        reload_in = 1'h0;
        reload_err_in = 1'h0;
    end
    // Toggle the count input once
    task automatic step();
        @(posedge clk);
        count_pulse_in <= ~count_pulse_in;
    endtask
    // Set the reload input level
    task automatic rset(input logic v);
        @(posedge clk);
        reload_in <= v;
    endtask
    // Error flags ride the same clock as their inputs
    task automatic set_err(input logic c, input logic r);
        @(posedge clk);
        count_err_in <= c;
        reload_err_in <= r;
    endtask
endmodule

/* verilog/counter_pkg.sv */
// Shared constants and types for the event counter.
// Assumes one 25 MHz clock and an APB register bus.
package counter_pkg;

    // ----------------------------------------
    // Count range
    // ----------------------------------------
    localparam int CNT_W = 14;                     // Count width
    typedef logic [CNT_W-1:0] count_type;          // Count value
    localparam count_type COUNT_ZERO = 14'h0000;   // Bottom of range
    localparam count_type COUNT_MAX  = 14'h270F;   // Top of range
    localparam count_type COUNT_ONE  = 14'h0001;   // Step size
    localparam count_type LOAD_RST   = 14'h0000;   // Load value at reset
    localparam count_type TARGET_RST = 14'h0000;   // Target at reset
    localparam logic [31:0] COUNT_MAX_W = 32'h0000270F; // Range top, wide

    // ----------------------------------------
    // Edge selections
    // ----------------------------------------
    typedef logic [1:0] edge_type;                 // Edge selector
    localparam edge_type EDGE_BOTH = 2'h0;         // Both transitions
    localparam edge_type EDGE_RISE = 2'h1;         // Off to on
    localparam edge_type EDGE_FALL = 2'h2;         // On to off

    // ----------------------------------------
    // APB register map
    // ----------------------------------------
    localparam int ADDR_W = 12;                    // Byte address width
    localparam logic [11:0] CTRL_OFF   = 12'h000;  // Control
    localparam logic [11:0] TARGET_OFF = 12'h004;  // Target value
    localparam logic [11:0] LOAD_OFF   = 12'h008;  // Load value
    localparam logic [11:0] STATUS_OFF = 12'h00C;  // Count and flags

    // ----------------------------------------
    // Control fields
    // ----------------------------------------
    localparam int CTRL_W         = 5;             // Control width
    localparam int CTRL_DOWN_BIT  = 0;             // 1 = count down
    localparam int CTRL_LATCH_BIT = 1;             // 1 = latch output
    localparam int CTRL_CEDGE_LSB = 2;             // Count edge, 2 bits
    localparam int CTRL_REDGE_BIT = 4;             // 1 = reload on rise
    localparam logic [4:0] CTRL_RST = 5'h11;       // Down, reload on rise

    // ----------------------------------------
    // Status fields
    // ----------------------------------------
    localparam int STAT_HIT_BIT  = 16;             // Target hit
    localparam int STAT_CERR_BIT = 17;             // Count input error
    localparam int STAT_RERR_BIT = 18;             // Reload input error

endpackage

/* verilog/down_event_counter.sv */
// Event counter with load, target and latching output, APB registers.
// Assumes synchronous inputs, each with an error flag on the same clock.
//
// Decided for this implementation: the register offsets and the APB interface to the registers.
module down_event_counter (
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic [counter_pkg::ADDR_W-1:0] paddr,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [31:0]                pwdata,
    output logic [31:0]                     prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic                       count_pulse_in,
    input  wire logic                       count_err_in,
    input  wire logic                       reload_in,
    input  wire logic                       reload_err_in,
    output logic                            target_hit
);
    import counter_pkg::*;

    // ----------------------------------------
    // Overview
    // ----------------------------------------
    // Two edge qualifiers, one per digital input
    // Each turns the chosen transition into a one-cycle pulse
    // At most one event per clock reaches the count
    // Reload beats a counting step in the same cycle
    // Each error flag gates only its own input
    // Both flags high: the count is frozen outright
    // Compare never looks at the error flags
    // Latch state tracks even while latching is off
    // Turning latching on can show an old hit at once
    // Output and read data straight from flip-flops
    // Four word registers, all in one aligned block
    // Slave never waits: one setup, one access cycle
    // Values above the range clip to its top

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic [CTRL_W-1:0] ctrl_r;      // Control register
    logic [CTRL_W-1:0] ctrl_nxt;
    count_type         target_r;    // Target value
    count_type         target_nxt;
    count_type         load_r;      // Load value
    count_type         load_nxt;
    count_type         count_r;     // Current count
    count_type         count_nxt;
    logic              latch_r;     // Latched hit
    logic              latch_nxt;
    logic              hit_r;       // Registered output
    logic              hit_nxt;
    logic [31:0]       prdata_r;    // Read data
    logic [31:0]       prdata_nxt;
    logic              cerr_r;      // Count error seen last cycle
    logic              cerr_nxt;
    logic              rerr_r;      // Reload error seen last cycle
    logic              rerr_nxt;

    logic              mode_down;   // Direction select
    logic              latch_en;    // Latching select
    edge_type          cnt_edge;    // Count edge select
    edge_type          rld_edge;    // Reload edge select
    logic              step_ok;     // Counting step taken
    logic              reload_ok;   // Reload taken
    logic              eq_nxt;      // Next count equals next target
    logic              addr_ok;     // Address is mapped
    logic              wr_acc;      // Write access phase
    logic              rd_setup;    // Read setup phase

    // ----------------------------------------
    // Edge qualifiers
    // ----------------------------------------
    edge_if cnt_if ();              // Count input link
    edge_if rld_if ();              // Reload input link

    // Feed the qualifiers
    // Edge selects follow the control register at once
    always_comb begin
        cnt_if.sig  = count_pulse_in;
        cnt_if.mode = cnt_edge;
        rld_if.sig  = reload_in;
        rld_if.mode = rld_edge;
    end

    // Count input qualifier
    // Disarmed for one edge after reset, so no false edge
    edge_qualifier u_cnt_edge (
        .clk (clk),
        .rst (rst),
        .e   (cnt_if)
    );

    // Reload input qualifier
    edge_qualifier u_rld_edge (
        .clk (clk),
        .rst (rst),
        .e   (rld_if)
    );

    // ----------------------------------------
    // Helpers
    // ----------------------------------------

    // Over-range writes clip to the top, never wrap
    // A stray large write then stays far from zero
    // Limit a written value to the count range
    function automatic count_type clip(input logic [31:0] v);
        if (v > COUNT_MAX_W) begin
            return COUNT_MAX;
        end
        return v[CNT_W-1:0];
    endfunction

    // One step with wrap at both ends
    // Down past zero lands on the top of the range
    // Up past the top lands on zero
    // The count can never leave the range
    function automatic count_type step(input count_type c,
                                       input logic down);
        if (down) begin
            if (c == COUNT_ZERO) begin
                return COUNT_MAX;
            end
            return c - COUNT_ONE;
        end
        if (c == COUNT_MAX) begin
            return COUNT_ZERO;
        end
        return c + COUNT_ONE;
    endfunction

    // ----------------------------------------
    // Control decode
    // ----------------------------------------

    // Split the control register into fields
    always_comb begin
        mode_down = ctrl_r[CTRL_DOWN_BIT];
        latch_en  = ctrl_r[CTRL_LATCH_BIT];
        cnt_edge  = ctrl_r[CTRL_CEDGE_LSB +: 2];
        // Count edge code 3 qualifies no transition at all
        // Reload edge: one bit maps to rise or fall
        // Both-edges reload is not offered
        if (ctrl_r[CTRL_REDGE_BIT]) begin
            rld_edge = EDGE_RISE;
        end else begin
            rld_edge = EDGE_FALL;
        end
    end

    // ----------------------------------------
    // APB slave
    // ----------------------------------------

    // Decode address and phases
    // No wait states: pready is tied high
    // Slave error only in the access phase of an unmapped word
    // Unaligned offsets count as unmapped
    always_comb begin
        addr_ok  = (paddr == CTRL_OFF) || (paddr == TARGET_OFF) ||
                   (paddr == LOAD_OFF) || (paddr == STATUS_OFF);
        wr_acc   = psel & penable & pwrite & addr_ok;
        rd_setup = psel & ~penable & ~pwrite;
        pready   = 1'b1;                    // Never waits
        pslverr  = psel & penable & ~addr_ok;
        prdata   = prdata_r;
    end

    // Register writes and read data capture
    always_comb begin
        ctrl_nxt   = ctrl_r;
        target_nxt = target_r;
        load_nxt   = load_r;
        prdata_nxt = prdata_r;
        // Writes land at the access phase
        if (wr_acc) begin
            unique case (paddr)
                CTRL_OFF:   ctrl_nxt   = pwdata[CTRL_W-1:0];
                TARGET_OFF: target_nxt = clip(pwdata);
                LOAD_OFF:   load_nxt   = clip(pwdata);
                default:    ;                // Status is read only
            endcase
        end
        // Read data prepared in the setup phase
        // Held in its flip-flop until the next read setup
        // Upper bits always read as zero
        if (rd_setup) begin
            prdata_nxt = 32'h00000000;
            unique case (paddr)
                CTRL_OFF:   prdata_nxt[CTRL_W-1:0] = ctrl_r;
                TARGET_OFF: prdata_nxt[CNT_W-1:0]  = target_r;
                LOAD_OFF:   prdata_nxt[CNT_W-1:0]  = load_r;
                STATUS_OFF: begin
                    prdata_nxt[CNT_W-1:0]       = count_r;
                    prdata_nxt[STAT_HIT_BIT]    = hit_r;
                    prdata_nxt[STAT_CERR_BIT]   = cerr_r;
                    prdata_nxt[STAT_RERR_BIT]   = rerr_r;
                end
                default:    ;                // Unmapped reads zero
            endcase
        end
    end

    // Register file update
    // Reset values come from the package
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_r   <= CTRL_RST;
            target_r <= TARGET_RST;
            load_r   <= LOAD_RST;
            prdata_r <= 32'h00000000;
        end else begin
            ctrl_r   <= ctrl_nxt;
            target_r <= target_nxt;
            load_r   <= load_nxt;
            prdata_r <= prdata_nxt;
        end
    end

    // ----------------------------------------
    // Counter core
    // ----------------------------------------

    // Next count, latch and output
    always_comb begin
        // Error flags gate each input on its own
        // A refused edge is consumed, never replayed later
        // Error flags share the clock of their inputs
        step_ok   = cnt_if.pulse & ~count_err_in;
        reload_ok = rld_if.pulse & ~reload_err_in;
        cerr_nxt  = count_err_in;
        rerr_nxt  = reload_err_in;
        count_nxt = count_r;
        // Reload has priority over a step in the same cycle
        if (reload_ok) begin
            count_nxt = load_r;
        end else if (step_ok) begin
            count_nxt = step(count_r, mode_down);
        end
        // Compare ignores input errors entirely
        // Next count against next target: the output moves
        // on the same edge as the count or a target write
        eq_nxt = (count_nxt == target_nxt);
        // Latch clears on reload, sets on a match
        // A match in the reload cycle still sets it
        if (reload_ok) begin
            latch_nxt = eq_nxt;
        end else begin
            latch_nxt = latch_r | eq_nxt;
        end
        // Select latched or plain compare
        if (latch_en) begin
            hit_nxt = latch_nxt;
        end else begin
            hit_nxt = eq_nxt;
        end
    end

    // Counter registers
    // Power-up count is the reset load value
    // Hit starts high when reset load equals reset target
    // Error copies run one cycle late and are not sticky
    always_ff @(posedge clk) begin
        if (rst) begin
            count_r <= LOAD_RST;
            latch_r <= 1'b0;
            hit_r   <= (LOAD_RST == TARGET_RST);
            cerr_r  <= 1'b0;
            rerr_r  <= 1'b0;
        end else begin
            count_r <= count_nxt;
            latch_r <= latch_nxt;
            hit_r   <= hit_nxt;
            cerr_r  <= cerr_nxt;
            rerr_r  <= rerr_nxt;
        end
    end

    // Output straight from its flip-flop
    // No error state can ever reach the output
    always_comb begin
        target_hit = hit_r;
    end

endmodule

/* verilog/edge_if.sv */
// Carrier between the counter core and an edge qualifier.
// Assumes the input is already synchronous to clk.
interface edge_if;
    import counter_pkg::*;
    logic     sig;    // Sampled digital input
    edge_type mode;   // Which transitions qualify
    logic     pulse;  // One-cycle qualifying transition

    // Qualifier side
    modport qual (input sig, input mode, output pulse);
    // Core side
    modport user (output sig, output mode, input pulse);
endinterface

/* verilog/edge_qualifier.sv */
// Edge qualifier for one digital input.
// Assumes the input is synchronous to clk; reset is synchronous.
module edge_qualifier (
    input  wire logic clk,
    input  wire logic rst,
    edge_if.qual      e
);
    import counter_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic prev_r;    // Last sampled level
    logic prev_nxt;
    logic armed_r;   // Blocks a false edge right after reset
    logic armed_nxt;
    logic rise;      // Off to on seen
    logic fall;      // On to off seen

    // Next state and pulse decode
    always_comb begin
        prev_nxt  = e.sig;
        armed_nxt = 1'b1;
        rise      = armed_r & e.sig & ~prev_r;
        fall      = armed_r & ~e.sig & prev_r;
        unique case (e.mode)
            EDGE_BOTH: e.pulse = rise | fall;
            EDGE_RISE: e.pulse = rise;
            EDGE_FALL: e.pulse = fall;
            default:   e.pulse = 1'b0;   // Unused code counts nothing
        endcase
    end

    // Register update
    always_ff @(posedge clk) begin
        if (rst) begin
            prev_r  <= 1'b0;
            armed_r <= 1'b0;
        end else begin
            prev_r  <= prev_nxt;
            armed_r <= armed_nxt;
        end
    end

endmodule
